/* design/thf_map.svh */
/*
  Register offsets, field positions, reset values and bit timing of the
  transmit header field block.
  Assumes byte addresses on an 8-bit control port with 8-bit data.
*/
// Contract
// - one 16-bit delimiter serves transmit and receive
// - delimiter high gives bits 15:8, low 7:0
// - service register value goes into every header
// - length field from high D0h, low D4h
// - length counts data bits incl. MAC header
// - zero length: modem resets right after delimiter
// - CRC16 inserted in header, high byte readable
// - header mode bits select CRC coverage
// - mode 0 no CRC, mode 1 delimiter only
// - CRC low byte readable at DCh
`ifndef THF_MAP_SVH
`define THF_MAP_SVH

// ==========================================================
// register offsets
`define THF_OFS_HDR_MODE 8'h08
`define THF_OFS_STATUS 8'h0c
`define THF_OFS_FRAME_DELIMITER_HIGH 8'hc4
`define THF_OFS_FRAME_DELIMITER_LOW 8'hc8
`define THF_OFS_SERVICE 8'hcc
`define THF_OFS_LEN_HIGH 8'hd0
`define THF_OFS_LEN_LOW 8'hd4
`define THF_OFS_CRC_HIGH 8'hd8
`define THF_OFS_CRC_LOW 8'hdc

// ==========================================================
// fields and reset values
`define THF_MODE_LSB 0
`define THF_MODE_MSB 1
`define THF_STAT_BUSY 0
`define THF_RST_BYTE 8'h00
`define THF_RST_MODE 2'h0

// ==========================================================
// crc
`define THF_CRC_POLY 16'h1021
`define THF_CRC_PRESET 16'hffff

// ==========================================================
// bit timing
`define THF_CLK_MHZ 125
`define THF_BIT_NS 1000
`define THF_BIT_CYC ((`THF_BIT_NS * `THF_CLK_MHZ) / 1000)

`endif

/* design/thf_pkg.sv */
/*
  Types of the transmit header field block.
  Assumes thf_map.svh for all numeric constants.
*/
package thf_pkg;

  // ==========================================================
  // header sequencer, gray from idle through crc to data, not on the return to idle
  typedef enum logic [2:0] {
    THF_IDLE = 3'h0,
    THF_SFD = 3'h1,
    THF_SIG = 3'h3,
    THF_SVC = 3'h2,
    THF_LEN = 3'h6,
    THF_CRC = 3'h7,
    THF_DATA = 3'h5
  } thf_state_t;

  typedef logic [1:0] thf_mode_t;

  // ==========================================================
  // whole state of the block
  typedef struct packed {
    logic [7:0] frame_delimiter_high;
    logic [7:0] frame_delimiter_low;
    logic [7:0] service;
    logic [7:0] len_high;
    logic [7:0] len_low;
    thf_mode_t hdr_mode;
    logic [15:0] crc_shown;
    logic [7:0] rdata;
    thf_state_t state;
    thf_mode_t run_mode;
    logic [7:0] run_sig;
    logic [7:0] run_svc;
    logic [15:0] run_len;
    logic [15:0] shreg;
    logic [3:0] bit_cnt;
    logic [15:0] crc;
    logic [15:0] data_cnt;
    logic [7:0] div_cnt;
    logic tx_bit;
    logic tx_strobe;
    logic data_req;
    logic hdr_done;
    logic tx_done;
    logic modem_reset;
  } thf_regs_t;

endpackage

/* design/thf_top.sv */
/*
  Transmit header field registers and header serialiser: delimiter,
  signalling, service, length and CRC16 go out one bit per bit slot,
  then the data phase is counted out in bits.
  Assumes a control port master that never issues read and write
  together, and a signalling byte stable when tx_start is pulsed.
*/
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps
`include "thf_map.svh"

module thf_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // control port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // transmit control
  input wire logic tx_start,
  input wire logic [7:0] signal_field,
  output logic tx_busy,
  // serial header and data pacing
  output logic tx_bit,
  output logic tx_strobe,
  output logic data_req,
  output logic hdr_done,
  output logic tx_done,
  output logic modem_reset,
  // receive side delimiter
  output logic [15:0] rx_sfd_value
);
  import thf_pkg::*;

  localparam logic [7:0] BIT_LAST = 8'(`THF_BIT_CYC - 1);

  thf_regs_t cur_ff;
  thf_regs_t nxt_cur;

  // ==========================================================
  // helpers
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    logic fb;
    fb = c[15] ^ b;
    crc_step = {c[14:0], 1'b0} ^ (fb ? `THF_CRC_POLY : 16'h0000);
  endfunction

  function automatic logic [15:0] rev16(input logic [15:0] v);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      r[i] = v[15 - i];
    end
    rev16 = r;
  endfunction

  // whether the field being sent feeds the crc in a given mode
  function automatic logic crc_covers(input thf_state_t s, input thf_mode_t m);
    logic c;
    c = 1'b0;
    unique case (m)
      2'h0: c = 1'b0;
      2'h1: c = (s == THF_SFD);
      2'h2: c = (s == THF_SFD) || (s == THF_LEN);
      2'h3: c = (s == THF_SIG) || (s == THF_SVC) || (s == THF_LEN);
    endcase
    crc_covers = c;
  endfunction

  // ==========================================================
  // next state
  always_comb begin
    logic bit_en;
    logic cur_bit;
    logic field_end;
    logic [15:0] crc_next;
    bit_en = 1'b0;
    cur_bit = 1'b0;
    field_end = 1'b0;
    crc_next = 16'h0000;
    nxt_cur = cur_ff;
    nxt_cur.tx_strobe = 1'b0;
    nxt_cur.data_req = 1'b0;
    nxt_cur.hdr_done = 1'b0;
    nxt_cur.tx_done = 1'b0;
    nxt_cur.modem_reset = 1'b0;
    nxt_cur.rdata = 8'h00;

    // control port writes
    if (reg_wr) begin
      unique case (reg_addr)
        `THF_OFS_FRAME_DELIMITER_HIGH: nxt_cur.frame_delimiter_high = reg_wdata;
        `THF_OFS_FRAME_DELIMITER_LOW: nxt_cur.frame_delimiter_low = reg_wdata;
        `THF_OFS_SERVICE: nxt_cur.service = reg_wdata;
        `THF_OFS_LEN_HIGH: nxt_cur.len_high = reg_wdata;
        `THF_OFS_LEN_LOW: nxt_cur.len_low = reg_wdata;
        `THF_OFS_HDR_MODE: nxt_cur.hdr_mode = reg_wdata[`THF_MODE_MSB:`THF_MODE_LSB];
        default: ;
      endcase
    end

    // control port reads, data stand the next cycle only
    if (reg_rd) begin
      unique case (reg_addr)
        `THF_OFS_FRAME_DELIMITER_HIGH: nxt_cur.rdata = cur_ff.frame_delimiter_high;
        `THF_OFS_FRAME_DELIMITER_LOW: nxt_cur.rdata = cur_ff.frame_delimiter_low;
        `THF_OFS_SERVICE: nxt_cur.rdata = cur_ff.service;
        `THF_OFS_LEN_HIGH: nxt_cur.rdata = cur_ff.len_high;
        `THF_OFS_LEN_LOW: nxt_cur.rdata = cur_ff.len_low;
        `THF_OFS_HDR_MODE: nxt_cur.rdata = {6'h00, cur_ff.hdr_mode};
        `THF_OFS_CRC_HIGH: nxt_cur.rdata = cur_ff.crc_shown[15:8];
        `THF_OFS_CRC_LOW: nxt_cur.rdata = cur_ff.crc_shown[7:0];
        `THF_OFS_STATUS: nxt_cur.rdata = {7'h00, cur_ff.state != THF_IDLE};
        default: nxt_cur.rdata = 8'h00;
      endcase
    end

    // bit slot divider, restarted at each frame
    if (cur_ff.state != THF_IDLE) begin
      if (cur_ff.div_cnt == BIT_LAST) begin
        nxt_cur.div_cnt = 8'h00;
        bit_en = 1'b1;
      end else begin
        nxt_cur.div_cnt = cur_ff.div_cnt + 8'h01;
      end
    end

    cur_bit = cur_ff.shreg[0];
    crc_next = crc_covers(cur_ff.state, cur_ff.run_mode) ?
      crc_step(cur_ff.crc, cur_bit) : cur_ff.crc;

    unique case (cur_ff.state)
      THF_IDLE: begin
        if (tx_start) begin
          nxt_cur.state = THF_SFD;
          nxt_cur.shreg = {cur_ff.frame_delimiter_high, cur_ff.frame_delimiter_low};
          nxt_cur.bit_cnt = 4'h0;
          nxt_cur.div_cnt = 8'h00;
          nxt_cur.crc = `THF_CRC_PRESET;
          nxt_cur.run_mode = cur_ff.hdr_mode;
          nxt_cur.run_sig = signal_field;
          nxt_cur.run_svc = cur_ff.service;
          nxt_cur.run_len = {cur_ff.len_high, cur_ff.len_low};
        end
      end
      THF_SFD, THF_SIG, THF_SVC, THF_LEN, THF_CRC: begin
        if (bit_en) begin
          nxt_cur.tx_bit = cur_bit;
          nxt_cur.tx_strobe = 1'b1;
          nxt_cur.shreg = {1'b0, cur_ff.shreg[15:1]};
          nxt_cur.bit_cnt = cur_ff.bit_cnt + 4'h1;
          if (cur_ff.state != THF_CRC) begin
            nxt_cur.crc = crc_next;
          end
          if (cur_ff.state == THF_SIG || cur_ff.state == THF_SVC) begin
            field_end = (cur_ff.bit_cnt == 4'h7);
          end else begin
            field_end = (cur_ff.bit_cnt == 4'hf);
          end
        end
        if (field_end) begin
          nxt_cur.bit_cnt = 4'h0;
          unique case (cur_ff.state)
            THF_SFD: begin
              if (cur_ff.run_len == 16'h0000) begin
                // zero length: abandon frame and reset right after delimiter
                nxt_cur.state = THF_IDLE;
                nxt_cur.modem_reset = 1'b1;
                nxt_cur.tx_done = 1'b1;
              end else begin
                nxt_cur.state = THF_SIG;
                nxt_cur.shreg = {8'h00, cur_ff.run_sig};
              end
            end
            THF_SIG: begin
              nxt_cur.state = THF_SVC;
              nxt_cur.shreg = {8'h00, cur_ff.run_svc};
            end
            THF_SVC: begin
              nxt_cur.state = THF_LEN;
              nxt_cur.shreg = cur_ff.run_len;
            end
            THF_LEN: begin
              if (cur_ff.run_mode == 2'h0) begin
                // no crc field at all in this mode
                nxt_cur.state = THF_DATA;
                nxt_cur.data_cnt = cur_ff.run_len;
                nxt_cur.hdr_done = 1'b1;
              end else begin
                nxt_cur.state = THF_CRC;
                nxt_cur.shreg = rev16(crc_next);
                nxt_cur.crc_shown = crc_next;
              end
            end
            THF_CRC: begin
              nxt_cur.state = THF_DATA;
              nxt_cur.data_cnt = cur_ff.run_len;
              nxt_cur.hdr_done = 1'b1;
            end
            default: nxt_cur.state = THF_IDLE;
          endcase
        end
      end
      THF_DATA: begin
        // one request per data bit, mac payload header bits included
        if (bit_en) begin
          nxt_cur.data_req = 1'b1;
          nxt_cur.data_cnt = cur_ff.data_cnt - 16'h0001;
          if (cur_ff.data_cnt == 16'h0001) begin
            nxt_cur.state = THF_IDLE;
            nxt_cur.tx_done = 1'b1;
          end
        end
      end
      default: nxt_cur.state = THF_IDLE;
    endcase
  end

  // ==========================================================
  // state register
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cur_ff <= '0;
      cur_ff.state <= THF_IDLE;
      cur_ff.hdr_mode <= `THF_RST_MODE;
      cur_ff.frame_delimiter_high <= `THF_RST_BYTE;
      cur_ff.frame_delimiter_low <= `THF_RST_BYTE;
      cur_ff.service <= `THF_RST_BYTE;
      cur_ff.crc <= `THF_CRC_PRESET;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ==========================================================
  // outputs
  assign reg_rdata = cur_ff.rdata;
  assign tx_busy = (cur_ff.state != THF_IDLE);
  assign tx_bit = cur_ff.tx_bit;
  assign tx_strobe = cur_ff.tx_strobe;
  assign data_req = cur_ff.data_req;
  assign hdr_done = cur_ff.hdr_done;
  assign tx_done = cur_ff.tx_done;
  assign modem_reset = cur_ff.modem_reset;
  // same delimiter the receive detector searches for
  assign rx_sfd_value = {cur_ff.frame_delimiter_high, cur_ff.frame_delimiter_low};

endmodule

/* test/thf_assertions.sv */
/*
  Timing checks on the transmit header field block's ports.
  Assumes the one system clock and the synchronous active-low reset.
*/
`timescale 1ns/100ps
module thf_assertions (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // watched ports
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic tx_start,
  input wire logic tx_busy,
  input wire logic tx_strobe,
  input wire logic data_req,
  input wire logic tx_done,
  input wire logic modem_reset
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // ==========================================================
  // control port
  chk_rdata_slot: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its slot");
  // ==========================================================
  // frame pacing
  chk_busy_take: assert property (!tx_busy && tx_start |=> tx_busy)
    else $error("start not taken");
  chk_first_slot: assert property ($rose(tx_busy) |-> ##125 tx_strobe)
    else $error("first bit late or early");
  chk_strobe_one: assert property (tx_strobe |=> !tx_strobe)
    else $error("strobe longer than one cycle");
  chk_slot_pace: assert property (tx_strobe && !tx_done |-> ##125 (tx_strobe || data_req))
    else $error("header slot spacing wrong");
  chk_req_pace: assert property (data_req && !tx_done |-> ##125 data_req)
    else $error("data slot spacing wrong");
  chk_abort_pair: assert property (modem_reset |-> tx_done && tx_strobe)
    else $error("modem reset not with last delimiter bit");
  chk_done_idle: assert property (tx_done |=> !tx_busy)
    else $error("busy after frame end");
  // last strobe or request of a frame shares its cycle with tx_done and idle
  chk_idle_quiet: assert property (!tx_busy && !tx_done |-> !tx_strobe && !data_req)
    else $error("activity while idle");
endmodule

bind thf_top thf_assertions chk_u (
  .sys_clk(sys_clk), .rstn(rstn), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .tx_start(tx_start), .tx_busy(tx_busy), .tx_strobe(tx_strobe),
  .data_req(data_req), .tx_done(tx_done), .modem_reset(modem_reset)
);

/* test/thf_host.sv */
/*
  Host model of the control port: one-cycle write and read strobes.
  Assumes read data stand only in the cycle after the read strobe.
*/
`timescale 1ns/100ps
module thf_host (
  // clock and read data
  input wire logic sys_clk,
  input wire logic [7:0] reg_rdata,
  // strobes
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
  end
  // caller keeps service at 00h and length nonzero unless testing abort
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    // mid-cycle sample avoids racing the registered data
    @(negedge sys_clk);
    d = reg_rdata;
  endtask
endmodule

/* test/thf_top_tb.sv */
/*
  Self-checking bench of the transmit header field block.
  Assumes thf_host drives the control port and the checker is bound.
*/
`timescale 1ns/100ps
`include "thf_map.svh"
module thf_top_tb;
  typedef struct packed {logic [7:0] a; logic [7:0] w; logic [7:0] e;} thf_row_t;
  logic sys_clk, rstn, tx_start, reg_wr, reg_rd, tx_busy, tx_bit, tx_strobe;
  logic data_req, hdr_done, tx_done, modem_reset;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, signal_field, d;
  logic [15:0] rx_sfd_value, c;
  logic [63:0] bits;
  int errors, checks, nstb, nreq, nmr, nhd;
  thf_row_t rows[8] = '{'{8'hc4, 8'h12, 8'h12}, '{8'hc8, 8'h34, 8'h34},
    '{8'hcc, 8'h00, 8'h00}, '{8'hd0, 8'h00, 8'h00}, '{8'hd4, 8'h02, 8'h02},
    '{8'h08, 8'h01, 8'h01}, '{8'hd8, 8'h55, 8'h00}, '{8'hf0, 8'haa, 8'h00}};

  thf_host host_u (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
  thf_top dut_u (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_start(tx_start), .signal_field(signal_field), .tx_busy(tx_busy),
    .tx_bit(tx_bit), .tx_strobe(tx_strobe), .data_req(data_req), .hdr_done(hdr_done),
    .tx_done(tx_done), .modem_reset(modem_reset), .rx_sfd_value(rx_sfd_value));

  // ==========================================================
  // clock, monitor, helpers
  initial begin
    sys_clk = 1'h0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (tx_strobe === 1'h1) begin
      bits[nstb] <= tx_bit;
      nstb <= nstb + 1;
    end
    nreq <= nreq + (data_req === 1'h1);
    nmr <= nmr + (modem_reset === 1'h1);
    nhd <= nhd + (hdr_done === 1'h1);
  end
  // bit-serial in send order, feedback on the top bit
  function automatic logic [15:0] crc_feed(logic [15:0] r, logic [15:0] v);
    for (int i = 0; i < 16; i++) begin
      r = {r[14:0], 1'h0} ^ ((r[15] ^ v[i]) ? `THF_CRC_POLY : 16'h0000);
    end
    return r;
  endfunction
  task chk(string n, logic [15:0] s, logic [15:0] e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task frame;
    @(negedge sys_clk);
    nstb = 0;
    nreq = 0;
    nmr = 0;
    nhd = 0;
    @(posedge sys_clk);
    tx_start <= 1'h1;
    @(posedge sys_clk);
    tx_start <= 1'h0;
    for (int k = 0; k < 20000 && tx_done !== 1'h1; k++) @(negedge sys_clk);
    @(negedge sys_clk);
  endtask
  task test_done;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    // four frames of 50 or 66 slots plus an abort, about 33000 cycles
    #500000;
    errors++;
    test_done;
  end

  // ==========================================================
  // tests
  initial begin
    rstn = 1'h0;
    tx_start = 1'h0;
    signal_field = 8'ha5;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'h1;
    foreach (rows[i]) begin
      host_u.wr(rows[i].a, rows[i].w);
      host_u.rd(rows[i].a, d);
      chk("register", {8'h00, d}, {8'h00, rows[i].e});
    end
    chk("rx delimiter", rx_sfd_value, 16'h1234);
    $display("test registers done");
    // every header mode; mode 0 first so the crc readback is still at reset
    for (int m = 0; m < 4; m++) begin
      host_u.wr(`THF_OFS_HDR_MODE, 8'(m));
      frame();
      c = `THF_CRC_PRESET;
      if (m == 1 || m == 2) c = crc_feed(c, 16'h1234);
      if (m == 3) c = crc_feed(c, 16'h00a5);
      if (m > 1) c = crc_feed(c, 16'h0002);
      chk("delimiter bits", bits[15:0], 16'h1234);
      chk("signal service bits", bits[31:16], 16'h00a5);
      chk("length bits", bits[47:32], 16'h0002);
      chk("strobes reqs", {nstb[7:0], nreq[7:0]}, {(m == 0) ? 8'h30 : 8'h40, 8'h02});
      chk("header end", nhd[15:0], 16'h0001);
      host_u.rd(`THF_OFS_CRC_HIGH, d);
      if (m == 0) begin
        chk("mode 0 crc unused", {8'h00, d}, 16'h0000);
      end else begin
        chk("crc high", {8'h00, d}, {8'h00, c[15:8]});
        for (int i = 0; i < 16; i++) begin
          chk("crc bit", {15'h0, bits[48 + i]}, {15'h0, c[15 - i]});
        end
        host_u.rd(`THF_OFS_CRC_LOW, d);
        chk("crc low", {8'h00, d}, {8'h00, c[7:0]});
      end
      $display("test mode %0d frame done", m);
    end
    // zero length in mode 0: abort right after the delimiter
    host_u.wr(8'hd4, 8'h00);
    host_u.wr(8'h08, 8'h00);
    frame();
    chk("abort counts", {nstb[7:0], nreq[3:0], nmr[3:0]}, 16'h1001);
    chk("abort header end", nhd[15:0], 16'h0000);
    $display("test zero length done");
    @(posedge sys_clk);
    rstn <= 1'h0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'h1;
    host_u.rd(8'hc4, d);
    chk("reset delimiter", {d, rx_sfd_value[7:0]}, 16'h0000);
    $display("test reset done");
    test_done;
  end
endmodule
